// >>> tb/adcc_analog_model.sv
// Analog pin model feeding the converter core
`timescale 1ns/10ps
`default_nettype none
module adcc_analog_model (
   // Core side
   input wire logic mclk,
   input wire logic [2:0] channelSel,
   input wire logic convPower,
   input wire logic [9:0] baseLevel,
   output logic [9:0] sampleValue
);
   logic [9:0] junk_q = 10'h2aa;
   always @(posedge mclk) junk_q <= ~junk_q;
   // Level of the selected pin, junk while unpowered
   assign sampleValue = convPower ?
      baseLevel ^ {channelSel, 7'h00} : junk_q;
endmodule : adcc_analog_model
`default_nettype wire

// >>> tb/adcc_properties.sv
// Concurrent checks on the converter control ports
`timescale 1ns/10ps
`default_nettype none
module adcc_properties #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // Bus
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   // Converter
   input wire logic [2:0] channelSel,
   input wire logic convPower,
   input wire logic sampleHold,
   input wire logic [7:0] pinAnalog,
   input wire logic conversionCompleteFlag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire acc = psel && penable;
   wire wr0 = acc && pwrite && paddr == 12'h07c;
   power_follow_a: assert property (wr0 |=> convPower == $past(pwdata[0]))
      else $error("power bit not applied");
   chan_follow_a: assert property (LARGE_VARIANT && wr0 |=>
      channelSel == $past(pwdata[5:3])) else $error("channel not applied");
   start_hold_a: assert property (wr0 && pwdata[2] && pwdata[0] &&
      convPower && !sampleHold |=> sampleHold) else $error("no start");
   off_nostart_a: assert property (wr0 && !convPower |=> !sampleHold)
      else $error("start while off");
   hold_len_a: assert property ($rose(sampleHold) |->
      (sampleHold || !convPower) [*8]) else $error("conversion too short");
   flag_done_a: assert property ($fell(sampleHold) && convPower |->
      ##[0:2] conversionCompleteFlag) else $error("flag not set");
   map_err_a: assert property (acc && !(paddr inside {12'h078, 12'h07c,
      12'h278, 12'h27c, 12'h280}) |-> pslverr) else $error("no slave error");
   power_abort_a: assert property ($fell(convPower) |-> ##[0:1] !sampleHold)
      else $error("converting while off");
   reset_pins_a: assert property ($rose(rst_n) |-> pinAnalog == 8'hff)
      else $error("pins not analog after reset");
endmodule : adcc_properties
bind adcc_conversion_control adcc_properties #(.LARGE_VARIANT(LARGE_VARIANT))
   u_props (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .channelSel(channelSel), .convPower(convPower), .sampleHold(sampleHold),
   .pinAnalog(pinAnalog), .conversionCompleteFlag(conversionCompleteFlag));
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic mclk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0;
   logic sleepMode = '0, pready, pslverr, err, convPower, sampleHold;
   logic hiRef, loRef, flag;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [2:0] channelSel;
   logic [7:0] pinAnalog;
   logic [9:0] sampleValue, level = '0;
   logic [15:0] lfsr = 16'h000a;
   int errors = 0, checks_done = 0, cyc = 0, n, ch, dv;
   int divs[8] = '{2, 8, 32, 800, 4, 16, 64, 800};
   adcc_conversion_control u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleepMode(sleepMode), .sampleValue(sampleValue),
      .channelSel(channelSel), .convPower(convPower), .sampleHold(sampleHold),
      .pinAnalog(pinAnalog), .highRefFromPin(hiRef), .lowRefFromPin(loRef),
      .conversionCompleteFlag(flag));
   adcc_analog_model u_pins (.mclk(mclk), .channelSel(channelSel),
      .convPower(convPower), .baseLevel(level), .sampleValue(sampleValue));
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr_next
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do @(posedge mclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic print_verdict;
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'h1;
      chk({24'h0, pinAnalog}, 32'h0000_00ff);
      apb(12'h07c, 1'h0, 32'h0);
      chk(rd, 32'h0);
      apb(12'h07c, 1'h1, 32'h0000_00fe);
      apb(12'h07c, 1'h0, 32'h0);
      chk(rd, 32'h0000_00f8);
      apb(12'h280, 1'h0, 32'h0);
      chk(rd, 32'h0);
      apb(12'h004, 1'h0, 32'h0);
      chk({31'h0, err}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         level <= lfsr[9:0];
         ch = int'(lfsr[12:10]);
         sleepMode <= (i % 4 == 3);
         apb(12'h27c, 1'h1, {24'h0, lfsr[13], i[2], 6'h00});
         apb(12'h07c, 1'h1, {24'h0, i[1:0], ch[2:0], 3'h1});
         apb(12'h07c, 1'h1, {24'h0, i[1:0], ch[2:0], 3'h5});
         dv = int'(level ^ {ch[2:0], 7'h00});
         n = 0;
         do begin
            apb(12'h07c, 1'h0, 32'h0);
            n++;
         end while (rd[2] === 1'h1);
         chk({31'h0, n > 1}, 32'h1);
         chk({31'h0, 3 * n >= 12 * divs[i]}, 32'h1);
         chk({31'h0, 3 * n <= 14 * divs[i] + 9}, 32'h1);
         apb(12'h280, 1'h0, 32'h0);
         chk(rd, 32'h1);
         apb(12'h280, 1'h1, 32'h1);
         apb(12'h078, 1'h0, 32'h0);
         chk(rd, lfsr[13] ? dv >> 8 : dv >> 2);
         apb(12'h278, 1'h0, 32'h0);
         chk(rd, lfsr[13] ? dv & 255 : (dv & 3) << 6);
      end
      sleepMode <= 1'h1;
      apb(12'h27c, 1'h1, 32'h0);
      apb(12'h07c, 1'h1, 32'h0000_0001);
      apb(12'h07c, 1'h1, 32'h0000_0005);
      repeat (40) @(posedge mclk);
      apb(12'h07c, 1'h0, 32'h0);
      chk(rd, 32'h0000_0005);
      sleepMode <= 1'h0;
      apb(12'h07c, 1'h1, 32'h0);
      apb(12'h07c, 1'h0, 32'h0);
      chk(rd, 32'h0);
      apb(12'h280, 1'h0, 32'h0);
      chk(rd, 32'h0);
      apb(12'h27c, 1'h1, 32'h0000_0001);
      #1;
      chk({22'h0, hiRef, loRef, pinAnalog}, 32'h0000_02f7);
      apb(12'h27c, 1'h1, 32'h0000_000f);
      #1;
      chk({22'h0, hiRef, loRef, pinAnalog}, 32'h0000_0301);
      @(posedge mclk);
      rst_n <= 1'h0;
      @(posedge mclk);
      rst_n <= 1'h1;
      #1;
      chk({24'h0, pinAnalog}, 32'h0000_00ff);
      print_verdict();
   end
endmodule : tb
`default_nettype wire

// >>> verilog/adcc_conversion_control.sv
// Conversion control of a 10-bit successive-approximation converter
//
// Implementation choice: the APB slave port.
`include "adcc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module adcc_conversion_control #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter core
   input wire logic sleepMode,
   input wire logic [9:0] sampleValue,
   output logic [2:0] channelSel,
   output logic convPower,
   output logic sampleHold,
   // Pin configuration
   output logic [7:0] pinAnalog,
   output logic highRefFromPin,
   output logic lowRefFromPin,
   // Completion
   output logic conversionCompleteFlag
);
   logic [7:0] ctrl0_q;
   logic [7:0] ctrl1_q;
   logic [9:0] result_q;
   logic [9:0] sampleReg_q;
   logic flag_q;
   logic [6:0] div_q;
   logic [9:0] rcDiv_q;
   logic [3:0] period_q;
   adcc_pkg::adcc_state_type state_q;
   logic tick;
   logic [7:0] idx;
   logic wrEn;
   logic rdEn;
   logic mapped;
   logic startReq;
   logic finish;
   logic [15:0] justified;
   logic [9:0] pinCfg;

   // Pin map: analog mask and reference use per port config code
   function automatic logic [9:0] pinMap(input logic [3:0] code);
      case (code)
         4'h0: pinMap = {8'hff, 2'b00};
         4'h1: pinMap = {8'hf7, 2'b10};
         4'h2: pinMap = {8'h1f, 2'b00};
         4'h3: pinMap = {8'h17, 2'b10};
         4'h4: pinMap = {8'h0b, 2'b00};
         4'h5: pinMap = {8'h03, 2'b10};
         4'h8: pinMap = {8'hf3, 2'b11};
         4'h9: pinMap = {8'h3f, 2'b00};
         4'ha: pinMap = {8'h37, 2'b10};
         4'hb: pinMap = {8'h33, 2'b11};
         4'hc: pinMap = {8'h13, 2'b11};
         4'hd: pinMap = {8'h03, 2'b11};
         4'he: pinMap = {8'h01, 2'b00};
         4'hf: pinMap = {8'h01, 2'b11};
         default: pinMap = {8'h00, 2'b00};
      endcase
   endfunction : pinMap

   assign idx = paddr[9:2];
   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && penable && !pwrite;
   assign mapped = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
      ((idx == `ADCC_IDX_RESH) || (idx == `ADCC_IDX_CTRL0) ||
       (idx == `ADCC_IDX_RESL) || (idx == `ADCC_IDX_CTRL1) ||
       (idx == `ADCC_IDX_STAT));
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Start only with power on and converter idle
   assign startReq = wrEn && (idx == `ADCC_IDX_CTRL0) && mapped &&
      pwdata[`ADCC_BIT_BUSY] && pwdata[`ADCC_BIT_POWER] &&
      ctrl0_q[`ADCC_BIT_POWER] && (state_q == adcc_pkg::ADCC_IDLE);

   // Conversion clock enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 7'h00;
      end else if (state_q == adcc_pkg::ADCC_IDLE) begin
         div_q <= 7'h00;
      end else begin
         div_q <= div_q + 7'h01;
      end
   end

   // RC divider restarts with each conversion so every period is whole
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rcDiv_q <= 10'h000;
      end else if ((state_q == adcc_pkg::ADCC_IDLE) ||
         (rcDiv_q == `ADCC_RC_DIV - 10'd1)) begin
         rcDiv_q <= 10'h000;
      end else begin
         rcDiv_q <= rcDiv_q + 10'h001;
      end
   end

   always_comb begin
      case ({ctrl1_q[`ADCC_BIT_CLKHI], ctrl0_q[7:6]})
         3'b000: tick = div_q[0:0] == 1'b1;
         3'b001: tick = div_q[2:0] == 3'h7;
         3'b010: tick = div_q[4:0] == 5'h1f;
         3'b100: tick = div_q[1:0] == 2'h3;
         3'b101: tick = div_q[3:0] == 4'hf;
         3'b110: tick = div_q[5:0] == 6'h3f;
         default: tick = rcDiv_q == `ADCC_RC_DIV - 10'd1;
      endcase
   end

   // Conversion sequencer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= adcc_pkg::ADCC_IDLE;
         period_q <= 4'h0;
      end else begin
         case (state_q)
            adcc_pkg::ADCC_IDLE: begin
               period_q <= 4'h0;
               if (startReq) begin
                  state_q <= adcc_pkg::ADCC_CONV;
               end
            end
            adcc_pkg::ADCC_CONV: begin
               if (!ctrl0_q[`ADCC_BIT_POWER]) begin
                  state_q <= adcc_pkg::ADCC_IDLE;
               end else if (sleepMode &&
                  (ctrl0_q[7:6] != 2'b11)) begin
                  state_q <= adcc_pkg::ADCC_CONV;
               end else if (tick) begin
                  if (period_q == `ADCC_CONV_PERIODS - 4'd1) begin
                     state_q <= adcc_pkg::ADCC_DONE;
                  end
                  period_q <= period_q + 4'h1;
               end
            end
            adcc_pkg::ADCC_DONE: begin
               state_q <= adcc_pkg::ADCC_IDLE;
            end
            default: begin
               state_q <= adcc_pkg::ADCC_IDLE;
            end
         endcase
      end
   end

   assign finish = state_q == adcc_pkg::ADCC_DONE;
   assign sampleHold = state_q == adcc_pkg::ADCC_CONV;

   // Sample captured on the accepted start write, before the first conversion period
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sampleReg_q <= 10'h000;
      end else if (startReq) begin
         sampleReg_q <= sampleValue;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= 10'h000;
      end else if (finish) begin
         result_q <= sampleReg_q;
      end
   end

   // Completion flag: set wins over software clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (finish) begin
         flag_q <= 1'b1;
      end else if (wrEn && mapped && (idx == `ADCC_IDX_STAT) &&
         pwdata[0]) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl0_q <= `ADCC_CTRL0_RST;
      end else if (wrEn && mapped && (idx == `ADCC_IDX_CTRL0)) begin
         ctrl0_q <= {pwdata[7:3], 2'b00, pwdata[0]};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl1_q <= `ADCC_CTRL1_RST;
      end else if (wrEn && mapped && (idx == `ADCC_IDX_CTRL1)) begin
         ctrl1_q <= {pwdata[7:6], 2'b00, pwdata[3:0]};
      end
   end

   assign justified = ctrl1_q[`ADCC_BIT_JUSTIFY] ?
      {6'h00, result_q} : {result_q, 6'h00};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite && !mapped) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr[9:2])
            `ADCC_IDX_RESH: prdata <= {24'h000000, justified[15:8]};
            `ADCC_IDX_RESL: prdata <= {24'h000000, justified[7:0]};
            `ADCC_IDX_CTRL0: prdata <= {24'h000000, ctrl0_q[7:3],
               (state_q != adcc_pkg::ADCC_IDLE), 1'b0, ctrl0_q[0]};
            `ADCC_IDX_CTRL1: prdata <= {24'h000000, ctrl1_q};
            `ADCC_IDX_STAT: prdata <= {31'h00000000, flag_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Channel select limited on the small variant
   assign channelSel = (LARGE_VARIANT || (ctrl0_q[5:3] <= 3'd4)) ?
      ctrl0_q[5:3] : 3'd0;
   assign convPower = ctrl0_q[`ADCC_BIT_POWER];
   assign pinCfg = pinMap(ctrl1_q[3:0]);
   assign pinAnalog = pinCfg[9:2] &
      (LARGE_VARIANT ? 8'hff : 8'h1f);
   assign highRefFromPin = pinCfg[1];
   assign lowRefFromPin = pinCfg[0];
   assign conversionCompleteFlag = flag_q;

   logic unusedRd;
   assign unusedRd = rdEn ^ (|pwdata[31:8]) ^ (|div_q[6:6]);
endmodule : adcc_conversion_control
`default_nettype wire

// >>> verilog/adcc_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_IDX_RESH 8'h1e
`define ADCC_IDX_CTRL0 8'h1f
`define ADCC_IDX_RESL 8'h9e
`define ADCC_IDX_CTRL1 8'h9f
`define ADCC_IDX_STAT 8'ha0
`define ADCC_IDX_SAMP 8'ha1
`define ADCC_CTRL0_RST 8'h00
`define ADCC_CTRL1_RST 8'h00
`define ADCC_BIT_POWER 0
`define ADCC_BIT_BUSY 2
`define ADCC_BIT_JUSTIFY 7
`define ADCC_BIT_CLKHI 6
`define ADCC_CONV_PERIODS 4'd12
`define ADCC_RC_DIV 10'd800
`endif

// >>> verilog/adcc_pkg.sv
// Types of the converter control block
package adcc_pkg;
   typedef enum logic [2:0] {
      ADCC_IDLE = 3'b001,
      ADCC_CONV = 3'b010,
      ADCC_DONE = 3'b100
   } adcc_state_type;
endpackage : adcc_pkg
